// >>> hw/ccr_channel_control.v
/*
 * Codec channel control register group behind the host command port.
 * Holds the operating-functions, interrupt-mask, operating-conditions and
 * transmit-gain words, the revision read-back, the default/programmed
 * coefficient steering and the decoded control levels.
 * Assumes command-port framing is done outside: each byte arrives as a
 * one-cycle strobe with a flag marking the command byte.
 */
`timescale 1ns/1ps
`include "ccr_defines.vh"

module ccr_channel_control #(
  parameter [7:0] REVISION = 8'h01, // arbitrary value
  parameter [15:0] GX_DEFAULT = 16'hA9F0,
  parameter GAIN_W = 20
) (
  input wire sys_clk,
  input wire arst_n,
  input wire host_cmd_valid,
  input wire host_cmd_is_cmd,
  input wire [7:0] host_cmd_data,
  input wire [3:0] chan_enable,
  output reg [7:0] host_rd_data,
  output reg host_rd_valid,
  input wire [3:0] first_realtime_input,
  input wire [3:0] second_realtime_input,
  output wire realtime_irq,
  output wire linear_coding,
  output wire mulaw_coding,
  output wire receive_gain_prog_sel,
  output wire transmit_gain_prog_sel,
  output wire transmit_eq_prog_sel,
  output wire receive_eq_prog_sel,
  output wire impedance_prog_sel,
  output wire balance_prog_sel,
  output wire balance_filter_enable,
  output wire [15:0] transmit_gain_active,
  output reg [GAIN_W-1:0] transmit_gain_value,
  output wire transmit_cutoff,
  output wire receive_cutoff,
  output wire highpass_bypass,
  output wire receive_loss_insert,
  output wire transmit_irq_arm,
  output wire interface_loopback,
  output wire full_loopback,
  output wire test_tone_on
);

  localparam ST_IDLE = 2'd0;
  localparam ST_DATA0 = 2'd1;
  localparam ST_DATA1 = 2'd2;

  reg [1:0] state_reg;
  reg [7:0] cmd_reg;
  reg [7:0] opfunc_reg;
  reg [7:0] irqmask_reg;
  reg [7:0] opcond_reg;
  reg [15:0] txgain_reg;
  reg [7:0] gain_hi_reg;
  // next values, copied into the registers on every edge
  reg [1:0] state_next;
  reg [7:0] cmd_next;
  reg [7:0] opfunc_next;
  reg [7:0] irqmask_next;
  reg [7:0] opcond_next;
  reg [15:0] txgain_next;
  reg [7:0] gain_hi_next;
  reg [7:0] rd_data_next;
  reg rd_valid_next;

  wire is_read = cmd_reg[`CCR_RW_BIT];
  wire [7:0] cmd_base = {cmd_reg[7:1], 1'b0};
  // command-gated accesses need at least one enabled channel
  wire chan_ok = |chan_enable;
  // mask and revision bypass the channel enables
  wire global_cmd = (cmd_base == `CCR_CMD_IRQMASK) || (cmd_reg == `CCR_CMD_REVISION);
  wire allowed = global_cmd || chan_ok;
  // a flagged byte is a command, any other valid byte fills the data slot
  wire cmd_strobe = host_cmd_valid && host_cmd_is_cmd;
  wire data_strobe = host_cmd_valid && !host_cmd_is_cmd;

  // one nested level: acc' = 1 + s*2^-m*acc, fixed point with 16 fraction bits
  function [GAIN_W-1:0] gx_level;
    input sign;
    input [2:0] shift;
    input [GAIN_W-1:0] acc;
    reg signed [GAIN_W-1:0] acc_s;
    reg signed [GAIN_W-1:0] one_s;
    reg signed [GAIN_W-1:0] term;
    begin
      // inner levels can go negative, so the shift has to keep the sign
      acc_s = acc;
      one_s = {{(GAIN_W-17){1'b0}}, `CCR_GAIN_ONE};
      term = acc_s >>> shift;
      if (sign) begin
        gx_level = one_s - term;
      end else begin
        gx_level = one_s + term;
      end
    end
  endfunction

  // read form of a command shares its upper bits, direction bit set
  function is_read_of;
    input [7:0] cmd;
    input [7:0] base;
    begin
      is_read_of = (cmd[7:1] == base[7:1]) && cmd[`CCR_RW_BIT];
    end
  endfunction

  // only defined read commands answer; other codes stay silent
  function known_read;
    input [7:0] cmd;
    begin
      known_read = is_read_of(cmd, `CCR_CMD_OPFUNC) || is_read_of(cmd, `CCR_CMD_IRQMASK) ||
        is_read_of(cmd, `CCR_CMD_OPCOND) || is_read_of(cmd, `CCR_CMD_TXGAIN) ||
        (cmd == `CCR_CMD_REVISION);
    end
  endfunction

  // read-back mux; register words come in as arguments so the decode sees them change
  function [7:0] rd_mux;
    input [7:0] cmd;
    input [1:0] phase;
    input [7:0] of;
    input [7:0] mk;
    input [7:0] oc;
    input [15:0] gx;
    begin
      if (is_read_of(cmd, `CCR_CMD_OPFUNC)) begin
        rd_mux = of;
      end else if (is_read_of(cmd, `CCR_CMD_IRQMASK)) begin
        rd_mux = mk;
      end else if (is_read_of(cmd, `CCR_CMD_OPCOND)) begin
        rd_mux = oc;
      end else if (cmd == `CCR_CMD_REVISION) begin
        rd_mux = REVISION;
      end else if (is_read_of(cmd, `CCR_CMD_TXGAIN)) begin
        rd_mux = (phase == ST_DATA0) ? gx[15:8] : gx[7:0];
      end else begin
        rd_mux = 8'h00;
      end
    end
  endfunction

  // next-value decode for the command sequencer and the register words
  always @* begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    opfunc_next = opfunc_reg;
    irqmask_next = irqmask_reg;
    opcond_next = opcond_reg;
    txgain_next = txgain_reg;
    gain_hi_next = gain_hi_reg;
    rd_data_next = host_rd_data;
    rd_valid_next = 1'b0;
    if (cmd_strobe) begin
      // a command byte always restarts the sequence
      cmd_next = host_cmd_data;
      state_next = ST_DATA0;
    end else if (data_strobe) begin
      case (state_reg)
        ST_IDLE: begin
          // stray data byte outside a sequence is dropped
          state_next = ST_IDLE;
        end
        ST_DATA0: begin
          state_next = ST_IDLE;
          if (allowed && is_read && known_read(cmd_reg)) begin
            rd_data_next = rd_mux(cmd_reg, state_reg, opfunc_reg, irqmask_reg, opcond_reg, txgain_reg);
            rd_valid_next = 1'b1;
            if (is_read_of(cmd_reg, `CCR_CMD_TXGAIN)) begin
              state_next = ST_DATA1;
            end
          end else if (allowed && !is_read) begin
            if (cmd_reg == `CCR_CMD_OPFUNC) begin
              opfunc_next = host_cmd_data;
            end else if (cmd_reg == `CCR_CMD_IRQMASK) begin
              irqmask_next = host_cmd_data;
            end else if (cmd_reg == `CCR_CMD_OPCOND) begin
              opcond_next = host_cmd_data;
            end else if (cmd_reg == `CCR_CMD_TXGAIN) begin
              gain_hi_next = host_cmd_data;
              state_next = ST_DATA1;
            end
          end
        end
        ST_DATA1: begin
          // second byte of the gain word, either direction
          state_next = ST_IDLE;
          if (is_read) begin
            rd_data_next = rd_mux(cmd_reg, state_reg, opfunc_reg, irqmask_reg, opcond_reg, txgain_reg);
            rd_valid_next = 1'b1;
          end else begin
            // word commits only once both bytes are in
            txgain_next = {gain_hi_reg, host_cmd_data};
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // every register reloads on each edge; holding is done by the decode above
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      cmd_reg <= 8'h00;
      opfunc_reg <= `CCR_OPFUNC_RESET;
      irqmask_reg <= `CCR_IRQMASK_RESET;
      opcond_reg <= `CCR_OPCOND_RESET;
      txgain_reg <= `CCR_TXGAIN_RESET;
      gain_hi_reg <= 8'h00;
      host_rd_data <= 8'h00;
      host_rd_valid <= 1'b0;
    end else begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      opfunc_reg <= opfunc_next;
      irqmask_reg <= irqmask_next;
      opcond_reg <= opcond_next;
      txgain_reg <= txgain_next;
      gain_hi_reg <= gain_hi_next;
      host_rd_data <= rd_data_next;
      host_rd_valid <= rd_valid_next;
    end
  end

  assign linear_coding = opfunc_reg[`CCR_OF_LINEAR];
  // mu-law only meaningful in compressed mode
  assign mulaw_coding = ~opfunc_reg[`CCR_OF_LINEAR] & opfunc_reg[`CCR_OF_MULAW];
  assign receive_gain_prog_sel = opfunc_reg[`CCR_OF_GR];
  assign transmit_gain_prog_sel = opfunc_reg[`CCR_OF_GX];
  assign transmit_eq_prog_sel = opfunc_reg[`CCR_OF_X];
  assign receive_eq_prog_sel = opfunc_reg[`CCR_OF_R];
  assign impedance_prog_sel = opfunc_reg[`CCR_OF_Z];
  assign balance_prog_sel = opfunc_reg[`CCR_OF_B];

  // fixed default word, never overwritten by host writes
  assign transmit_gain_active = transmit_gain_prog_sel ? txgain_reg : GX_DEFAULT;

  // byte1 = C40 m40 C30 m30, byte2 = C20 m20 C10 m10
  wire [7:0] gx_hi = transmit_gain_active[15:8];
  wire [7:0] gx_lo = transmit_gain_active[7:0];
  // magnitude stays within five, so twenty bits leave room for the sign
  reg [GAIN_W-1:0] gx_acc;
  always @* begin
    gx_acc = gx_level(gx_hi[7], gx_hi[6:4], {{(GAIN_W-17){1'b0}}, `CCR_GAIN_ONE});
    gx_acc = gx_level(gx_hi[3], gx_hi[2:0], gx_acc);
    gx_acc = gx_level(gx_lo[7], gx_lo[6:4], gx_acc);
    gx_acc = gx_level(gx_lo[3], gx_lo[2:0], gx_acc);
  end
  // registered for timing; value trails the word by one cycle
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      transmit_gain_value <= {GAIN_W{1'b0}};
    end else begin
      transmit_gain_value <= gx_acc;
    end
  end

  assign transmit_cutoff = opcond_reg[`CCR_OC_TXCUT];
  assign receive_cutoff = opcond_reg[`CCR_OC_RXCUT];
  assign balance_filter_enable = ~opcond_reg[`CCR_OC_RXCUT];
  assign highpass_bypass = opcond_reg[`CCR_OC_HPBYP];
  assign receive_loss_insert = opcond_reg[`CCR_OC_RXLOSS];
  assign transmit_irq_arm = opcond_reg[`CCR_OC_TXARM];
  assign interface_loopback = opcond_reg[`CCR_OC_IFLOOP];
  assign full_loopback = opcond_reg[`CCR_OC_FULLLOOP];
  assign test_tone_on = opcond_reg[`CCR_OC_TONE];

  // mask layout interleaves first/second input per channel
  wire [7:0] rt_bits = {second_realtime_input[3], first_realtime_input[3],
                        second_realtime_input[2], first_realtime_input[2],
                        second_realtime_input[1], first_realtime_input[1],
                        second_realtime_input[0], first_realtime_input[0]};
  assign realtime_irq = |(rt_bits & ~irqmask_reg);

endmodule

// >>> include/ccr_defines.vh
/*
 * Constants for the codec channel control register group: command codes,
 * field positions, reset values and the fixed-point unity gain.
 * Assumes inclusion by bare name from design files.
 */
`ifndef CCR_DEFINES_VH
`define CCR_DEFINES_VH

`define CCR_CMD_OPFUNC 8'h60
`define CCR_CMD_IRQMASK 8'h6C
`define CCR_CMD_OPCOND 8'h70
`define CCR_CMD_REVISION 8'h73
`define CCR_CMD_TXGAIN 8'h80
`define CCR_RW_BIT 0

`define CCR_OPFUNC_RESET 8'h00
`define CCR_IRQMASK_RESET 8'hFF
`define CCR_OPCOND_RESET 8'h00
`define CCR_TXGAIN_RESET 16'hA9F0
// unity gain with 16 fraction bits
`define CCR_GAIN_ONE 17'h10000

`define CCR_OF_LINEAR 7
`define CCR_OF_MULAW 6
`define CCR_OF_GR 5
`define CCR_OF_GX 4
`define CCR_OF_X 3
`define CCR_OF_R 2
`define CCR_OF_Z 1
`define CCR_OF_B 0

`define CCR_OC_TXCUT 7
`define CCR_OC_RXCUT 6
`define CCR_OC_HPBYP 5
`define CCR_OC_RXLOSS 4
`define CCR_OC_TXARM 3
`define CCR_OC_IFLOOP 2
`define CCR_OC_FULLLOOP 1
`define CCR_OC_TONE 0

`endif

// >>> verification/ccr_cc_monitor.sv
/* checker on the control register ports.
   assumes it is bound to ccr_channel_control. */
`timescale 1ns/1ps
module ccr_cc_monitor #(
  parameter [7:0] REVISION = 8'h01
) (
  input wire sys_clk,
  input wire arst_n,
  input wire host_cmd_valid,
  input wire host_cmd_is_cmd,
  input wire [7:0] host_cmd_data,
  input wire [3:0] chan_enable,
  input wire [7:0] host_rd_data,
  input wire host_rd_valid,
  input wire realtime_irq,
  input wire linear_coding,
  input wire mulaw_coding,
  input wire transmit_gain_prog_sel,
  input wire [15:0] transmit_gain_active,
  input wire balance_filter_enable,
  input wire receive_cutoff,
  input wire transmit_cutoff,
  input wire test_tone_on
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_cmd(c);
    host_cmd_valid && host_cmd_is_cmd && host_cmd_data == c;
  endsequence
  sequence s_dat;
    host_cmd_valid && !host_cmd_is_cmd;
  endsequence
  property p_irq_rst; $rose(arst_n) |-> !realtime_irq; endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
  property p_law; linear_coding |-> !mulaw_coding; endproperty
  a_law: assert property (p_law) else $error("law with linear");
  property p_bfilt; balance_filter_enable != receive_cutoff; endproperty
  a_bfilt: assert property (p_bfilt) else $error("b filter in cutoff");
  property p_gx_def; !transmit_gain_prog_sel |-> transmit_gain_active == 16'hA9F0; endproperty
  a_gx_def: assert property (p_gx_def) else $error("gain source");
  property p_wr; s_cmd(8'h70) ##1 (s_dat ##0 chan_enable != 4'h0) |=> transmit_cutoff == $past(host_cmd_data[7])
    && receive_cutoff == $past(host_cmd_data[6]) && test_tone_on == $past(host_cmd_data[0]); endproperty
  a_wr: assert property (p_wr) else $error("conditions write");
  property p_wr_quiet; s_cmd(8'h70) ##1 s_dat |=> !host_rd_valid; endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("write answered");
  property p_mask_rd; s_cmd(8'h6D) ##1 s_dat |=> host_rd_valid; endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask read");
  property p_rev; s_cmd(8'h73) ##1 s_dat |=> host_rd_valid && host_rd_data == REVISION; endproperty
  a_rev: assert property (p_rev) else $error("revision read");
endmodule
bind ccr_channel_control ccr_cc_monitor #(.REVISION(REVISION)) u_mon (.*);

// >>> verification/ccr_host_model.sv
/* host side of the command port.
   assumes seq is called just after a rising edge. */
`timescale 1ns/1ps
module ccr_host_model (
  input wire sys_clk,
  input wire host_rd_valid,
  input wire [7:0] host_rd_data,
  output logic host_cmd_valid = 1'b0,
  output logic host_cmd_is_cmd = 1'b0,
  output logic [7:0] host_cmd_data = 8'h00
);
  logic [15:0] rd_word = 16'h0000;
  int rd_cnt = 0;
  always @(posedge sys_clk) begin
    if (host_rd_valid) begin
      rd_word <= {rd_word[7:0], host_rd_data};
      rd_cnt <= rd_cnt + 1;
    end
  end
  task automatic seq(input logic [7:0] c, input logic [15:0] d, input int n);
    host_cmd_valid <= 1'b1;
    host_cmd_is_cmd <= 1'b1;
    host_cmd_data <= c;
    @(posedge sys_clk);
    host_cmd_is_cmd <= 1'b0;
    for (int i = n; i > 0; i--) begin
      host_cmd_data <= d[8*i-1 -: 8];
      @(posedge sys_clk);
    end
    host_cmd_valid <= 1'b0;
    host_cmd_data <= ~host_cmd_data; // released lines must not look stale
    repeat (2) @(posedge sys_clk);
  endtask
endmodule

// >>> verification/ccr_channel_control_bench.sv
/* self-checking bench for the channel control registers.
   assumes ccr_host_model drives the command port. */
`timescale 1ns/1ps
module ccr_channel_control_bench;
  logic sys_clk, arst_n, host_cmd_valid, host_cmd_is_cmd, host_rd_valid, realtime_irq;
  logic [7:0] host_cmd_data, host_rd_data, v, m;
  logic [3:0] chan_enable, first_realtime_input, second_realtime_input;
  logic linear_coding, mulaw_coding, receive_gain_prog_sel, transmit_gain_prog_sel, transmit_eq_prog_sel;
  logic receive_eq_prog_sel, impedance_prog_sel, balance_prog_sel, balance_filter_enable, transmit_cutoff;
  logic receive_cutoff, highpass_bypass, receive_loss_insert, transmit_irq_arm, interface_loopback;
  logic full_loopback, test_tone_on;
  logic [15:0] transmit_gain_active, g;
  logic [19:0] transmit_gain_value;
  int n_mismatch = 0, num_checks = 0, cnt;
  ccr_channel_control u_dut (.*);
  ccr_host_model u_host (.*);
  function automatic real gx_of(input logic [15:0] w);
    real t;
    t = 1.0;
    for (int k = 3; k >= 0; k--) t = 1.0 + (w[4*k+3] ? -t : t) / (2.0 ** w[4*k+2 -: 3]);
    return t;
  endfunction
  function automatic logic irq_of(input logic [7:0] mk, input logic [3:0] a, input logic [3:0] b);
    logic [7:0] rt;
    for (int c = 0; c < 4; c++) rt[2*c +: 2] = {b[c], a[c]};
    return |(rt & ~mk);
  endfunction
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    num_checks++;
    if (exp !== got) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] c, input int n, input logic [15:0] exp, input string what);
    cnt = u_host.rd_cnt;
    u_host.seq(c, 16'h0000, n);
    chk(what, 20'(n), 20'(u_host.rd_cnt - cnt));
    chk(what, exp, n == 2 ? u_host.rd_word : {8'h00, u_host.rd_word[7:0]});
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    arst_n = 1'b0;
    chan_enable = 4'hF;
    first_realtime_input = 4'hF;
    second_realtime_input = 4'hF;
    void'($urandom(98));
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    chk("irq", 0, realtime_irq);
    rd(8'h61, 1, 16'h0000, "opfunc");
    rd(8'h6D, 1, 16'h00FF, "mask");
    rd(8'h71, 1, 16'h0000, "opcond");
    rd(8'h81, 2, 16'hA9F0, "gx");
    chan_enable <= 4'h0;
    rd(8'h73, 1, 16'h0001, "rev");
    m = 8'($urandom);
    u_host.seq(8'h6C, {8'h00, m}, 1);
    rd(8'h6D, 1, {8'h00, m}, "mask_off");
    cnt = u_host.rd_cnt;
    u_host.seq(8'h70, 16'h00FF, 1);
    u_host.seq(8'h71, 16'h0000, 1);
    chk("refused", 0, 20'(u_host.rd_cnt - cnt));
    chk("tone_off", 0, test_tone_on);
    for (int i = 0; i < 10; i++) begin
      chan_enable <= 4'($urandom_range(15, 1));
      v = (i < 2) ? {8{i[0]}} : 8'($urandom);
      u_host.seq(8'h70, {8'h00, v}, 1);
      chk("opcond", v, {transmit_cutoff, receive_cutoff, highpass_bypass, receive_loss_insert, transmit_irq_arm,
        interface_loopback, full_loopback, test_tone_on});
      chk("bfilt", !v[6], balance_filter_enable);
      rd(8'h71, 1, {8'h00, v}, "opcond_rd");
      u_host.seq(8'h60, {8'h00, v}, 1);
      chk("opfunc", {v[7], v[6] & !v[7], v[5:0]}, {linear_coding, mulaw_coding, receive_gain_prog_sel,
        transmit_gain_prog_sel, transmit_eq_prog_sel, receive_eq_prog_sel, impedance_prog_sel, balance_prog_sel});
      g = 16'($urandom);
      u_host.seq(8'h80, g, 2);
      rd(8'h81, 2, g, "gx_rd");
      chk("gx_act", v[4] ? g : 16'hA9F0, transmit_gain_active);
      chk("gx_val", 1, (gx_of(v[4] ? g : 16'hA9F0) - $signed(transmit_gain_value) / 65536.0) ** 2 < 1e-8);
      m = 8'($urandom);
      first_realtime_input <= 4'($urandom);
      second_realtime_input <= 4'($urandom);
      u_host.seq(8'h6C, {8'h00, m}, 1);
      chk("irq", irq_of(m, first_realtime_input, second_realtime_input), realtime_irq);
    end
    // mid-run reset must bring back the mask, operating-conditions and gain reset words over live inputs
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    chk("irq_rst", 0, realtime_irq);
    chk("oc_rst", 0, {transmit_cutoff, receive_cutoff, highpass_bypass, receive_loss_insert, transmit_irq_arm,
      interface_loopback, full_loopback, test_tone_on});
    rd(8'h6D, 1, 16'h00FF, "mask_rst");
    rd(8'h81, 2, 16'hA9F0, "gx_rst");
    wrap_up();
  end
endmodule
